/* src/dtp_pkg.sv */
// Package for the dual timer with PWM and capture: register offsets, field layouts,
// reset values and clock selector codes.
// Assumes a 16-bit register port with byte offsets taken from the low address byte.
package dtp_pkg;

   // Data and address widths of the register port.
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;

   // Register offsets.
   localparam logic [7:0] OFS_COUNTER_ONE   = 8'h40;
   localparam logic [7:0] OFS_RELOAD_A      = 8'h42;
   localparam logic [7:0] OFS_RELOAD_B      = 8'h44;
   localparam logic [7:0] OFS_COUNTER_TWO   = 8'h46;
   localparam logic [7:0] OFS_PRESCALE      = 8'h48;
   localparam logic [7:0] OFS_CLOCK_SELECT  = 8'h4A;
   localparam logic [7:0] OFS_MODE_CONTROL  = 8'h4C;
   localparam logic [7:0] OFS_IRQ_CONTROL   = 8'h4E;
   localparam logic [7:0] OFS_IRQ_CLEAR     = 8'h50;

   // Clock selector codes; every other code is reserved and stops the counter.
   localparam logic [2:0] CLK_SEL_NONE      = 3'h0;
   localparam logic [2:0] CLK_SEL_PRESCALED = 3'h1;
   localparam logic [2:0] CLK_SEL_SLOW      = 3'h4;

   // Width of the prescaler and position of the pending bits in the interrupt control register.
   localparam int PRESCALE_W = 5;
   localparam int PEND_LSB   = 4;

   // Reset values and the capture preset value.
   localparam logic [4:0]  RST_PRESCALE  = 5'h00;
   localparam logic [15:0] RST_COUNTER   = 16'h0000;
   localparam logic [15:0] RST_RELOAD    = 16'h0000;
   localparam logic [15:0] PRESET_VALUE  = 16'hFFFF;

   // Mode control register layout.
   typedef struct packed {
      logic initial_pin_level;
      logic pin_function_enable;
      logic capture_falling;
      logic capture_mode;
   } dtp_mode_t;

   // Clock select register layout.
   typedef struct packed {
      logic [2:0] sel_two;
      logic [2:0] sel_one;
   } dtp_clk_sel_t;

   // Interrupt enable and pending bit layout.
   typedef struct packed {
      logic d;
      logic c;
      logic b;
      logic a;
   } dtp_irq_bits_t;

   localparam dtp_mode_t     RST_MODE       = 4'h0;
   localparam dtp_clk_sel_t  RST_CLOCK_SEL  = 6'h00;
   localparam dtp_irq_bits_t RST_IRQ_BITS   = 4'h0;

endpackage

/* src/dtp_sync_edge.sv */
// Two-stage synchronizer with edge detection for one asynchronous input.
// Assumes the input changes no faster than the clock can sample it.
`timescale 1ns/100ps
`default_nettype none
module dtp_sync_edge (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // First stage feeds only the second stage; the third stage holds the prior level.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Edge pulses last one clock.
   assign level = sync_reg;
   assign rise  = sync_reg & ~last_reg;
   assign fall  = ~sync_reg & last_reg;

endmodule
`default_nettype wire

/* src/dtp_timer.sv */
// Dual 16-bit down-counting timer with PWM output and input capture on one pin.
// Assumes a register master on clk, an asynchronous slow clock and an external pin driver.
`timescale 1ns/100ps
`default_nettype none
module dtp_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [dtp_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [dtp_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [dtp_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic                        slow_clk,
   input  wire logic                        timer_io_pin_in,
   output logic                             timer_io_pin_out,
   output logic                             timer_io_pin_oe,
   output logic                             irq_timer_one,
   output logic                             irq_timer_two
);

   // Reset release synchronizer.
   logic                         rst_meta_reg;
   logic                         rst_sync_reg;
   logic                         rst_n_s;

   // Register state.
   logic [CNT_W-1:0]             counter_one_reg;
   logic [CNT_W-1:0]             counter_two_reg;
   logic [CNT_W-1:0]             reload_capture_a_reg;
   logic [CNT_W-1:0]             reload_capture_b_reg;
   logic [dtp_pkg::PRESCALE_W-1:0] prescale_divisor_reg;
   logic [dtp_pkg::PRESCALE_W-1:0] prescale_count_reg;
   dtp_pkg::dtp_clk_sel_t        clock_select_reg;
   dtp_pkg::dtp_mode_t           mode_reg;
   dtp_pkg::dtp_irq_bits_t       irq_enable_reg;
   dtp_pkg::dtp_irq_bits_t       pend_reg;
   dtp_pkg::dtp_irq_bits_t       pend_next;
   dtp_pkg::dtp_irq_bits_t       pend_set;
   dtp_pkg::dtp_irq_bits_t       pend_clr;
   logic                         reload_from_a_reg;
   logic                         pin_out_reg;
   logic                         pin_oe_reg;
   logic [dtp_pkg::DATA_W-1:0]   rdata_reg;
   logic                         irq_one_reg;
   logic                         irq_two_reg;

   // Derived events.
   logic                         prescale_tick;
   logic                         slow_rise;
   logic                         pin_rise;
   logic                         pin_fall;
   logic                         tick_one;
   logic                         tick_two;
   logic                         run_one;
   logic                         run_two;
   logic                         underflow_one;
   logic                         underflow_two;
   logic                         capture_event;
   logic                         capture_preset;
   logic                         pwm_active;
   logic                         wr_counter_one;
   logic                         wr_counter_two;
   logic                         wr_reload_a;
   logic                         wr_reload_b;
   logic                         wr_prescale;
   logic                         wr_clock_select;
   logic                         wr_mode;
   logic                         wr_irq_control;
   logic                         wr_irq_clear;

   // Reset is taken asynchronously and released through two flip-flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_n_s = rst_sync_reg;

   // Slow clock and pin each pass a two-stage synchronizer before use.
   dtp_sync_edge u_slow_sync (
      .clk      (clk),
      .rst_n    (rst_n_s),
      .async_in (slow_clk),
      .level    (),
      .rise     (slow_rise),
      .fall     ()
   );

   dtp_sync_edge u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_n_s),
      .async_in (timer_io_pin_in),
      .level    (),
      .rise     (pin_rise),
      .fall     (pin_fall)
   );

   // Register write decode.
   assign wr_counter_one  = reg_wr && (reg_addr == dtp_pkg::OFS_COUNTER_ONE);
   assign wr_counter_two  = reg_wr && (reg_addr == dtp_pkg::OFS_COUNTER_TWO);
   assign wr_reload_a     = reg_wr && (reg_addr == dtp_pkg::OFS_RELOAD_A);
   assign wr_reload_b     = reg_wr && (reg_addr == dtp_pkg::OFS_RELOAD_B);
   assign wr_prescale     = reg_wr && (reg_addr == dtp_pkg::OFS_PRESCALE);
   assign wr_clock_select = reg_wr && (reg_addr == dtp_pkg::OFS_CLOCK_SELECT);
   assign wr_mode         = reg_wr && (reg_addr == dtp_pkg::OFS_MODE_CONTROL);
   assign wr_irq_control  = reg_wr && (reg_addr == dtp_pkg::OFS_IRQ_CONTROL);
   assign wr_irq_clear    = reg_wr && (reg_addr == dtp_pkg::OFS_IRQ_CLEAR);

   // Prescaler counts down and ticks at zero, then reloads the divisor.
   assign prescale_tick = (prescale_count_reg == '0);

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         prescale_count_reg <= dtp_pkg::RST_PRESCALE;
      end else if (prescale_tick) begin
         prescale_count_reg <= prescale_divisor_reg;
      end else begin
         prescale_count_reg <= prescale_count_reg - 5'h01;
      end
   end

   // Clock source selection; reserved codes stop the counter like no clock.
   assign run_one  = (clock_select_reg.sel_one == dtp_pkg::CLK_SEL_PRESCALED) ||
                     (clock_select_reg.sel_one == dtp_pkg::CLK_SEL_SLOW);
   assign run_two  = (clock_select_reg.sel_two == dtp_pkg::CLK_SEL_PRESCALED) ||
                     (clock_select_reg.sel_two == dtp_pkg::CLK_SEL_SLOW);
   assign tick_one = ((clock_select_reg.sel_one == dtp_pkg::CLK_SEL_PRESCALED) && prescale_tick) ||
                     ((clock_select_reg.sel_one == dtp_pkg::CLK_SEL_SLOW) && slow_rise);
   assign tick_two = run_two &&
                     ((clock_select_reg.sel_two == dtp_pkg::CLK_SEL_PRESCALED) ? prescale_tick : slow_rise);

   // Underflow is a tick arriving while the count is zero.
   assign underflow_one  = tick_one && (counter_one_reg == '0);
   assign underflow_two  = tick_two && (counter_two_reg == '0);
   assign pwm_active     = !mode_reg.capture_mode;
   assign capture_event  = mode_reg.capture_mode &&
                           (mode_reg.capture_falling ? pin_fall : pin_rise);
   assign capture_preset = capture_event && mode_reg.pin_function_enable;

   // Counter one: preset on capture, then reload or decrement on ticks, else software write.
   // Nothing advances without a clock edge, so a stopped system clock holds the count.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         counter_one_reg <= dtp_pkg::RST_COUNTER;
      end else if (capture_preset) begin
         counter_one_reg <= dtp_pkg::PRESET_VALUE;
      end else if (underflow_one && pwm_active) begin
         counter_one_reg <= reload_from_a_reg ? reload_capture_a_reg : reload_capture_b_reg;
      end else if (tick_one) begin
         counter_one_reg <= counter_one_reg - 16'h0001;
      end else if (wr_counter_one) begin
         counter_one_reg <= reload_data(reg_wdata);
      end
   end

   // Alternation pointer returns to A whenever counter one is stopped or not in PWM mode.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         reload_from_a_reg <= 1'b1;
      end else if (!run_one || !pwm_active) begin
         reload_from_a_reg <= 1'b1;
      end else if (underflow_one) begin
         reload_from_a_reg <= ~reload_from_a_reg;
      end
   end

   // Counter two is a plain down counter that wraps through all ones.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         counter_two_reg <= dtp_pkg::RST_COUNTER;
      end else if (tick_two) begin
         counter_two_reg <= counter_two_reg - 16'h0001;
      end else if (wr_counter_two) begin
         counter_two_reg <= reload_data(reg_wdata);
      end
   end

   // Reload/capture A takes the count on a capture, otherwise software writes it.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         reload_capture_a_reg <= dtp_pkg::RST_RELOAD;
      end else if (capture_event) begin
         reload_capture_a_reg <= counter_one_reg;
      end else if (wr_reload_a) begin
         reload_capture_a_reg <= reload_data(reg_wdata);
      end
   end

   // Reload B is written by software only.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         reload_capture_b_reg <= dtp_pkg::RST_RELOAD;
      end else if (wr_reload_b) begin
         reload_capture_b_reg <= reload_data(reg_wdata);
      end
   end

   // Control registers; clock select cleared at reset keeps both counters stopped.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         prescale_divisor_reg <= dtp_pkg::RST_PRESCALE;
         clock_select_reg     <= dtp_pkg::RST_CLOCK_SEL;
         mode_reg             <= dtp_pkg::RST_MODE;
         irq_enable_reg       <= dtp_pkg::RST_IRQ_BITS;
      end else begin
         if (wr_prescale) begin
            prescale_divisor_reg <= reg_wdata[dtp_pkg::PRESCALE_W-1:0];
         end
         if (wr_clock_select) begin
            clock_select_reg <= reg_wdata[5:0];
         end
         if (wr_mode) begin
            mode_reg <= reg_wdata[3:0];
         end
         if (wr_irq_control) begin
            irq_enable_reg <= reg_wdata[3:0];
         end
      end
   end

   // Pending flag sources per mode; a set in the clearing cycle wins.
   always_comb begin
      pend_set   = '0;
      pend_set.a = (pwm_active && underflow_one && reload_from_a_reg) || capture_event;
      pend_set.b = pwm_active && underflow_one && !reload_from_a_reg;
      pend_set.c = !pwm_active && underflow_one;
      pend_set.d = underflow_two;
      pend_clr   = wr_irq_clear ? dtp_pkg::dtp_irq_bits_t'(reg_wdata[3:0]) : '0;
      pend_next  = (pend_reg & ~pend_clr) | pend_set;
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         pend_reg <= dtp_pkg::RST_IRQ_BITS;
      end else begin
         pend_reg <= pend_next;
      end
   end

   // Interrupt outputs: sources A, B and C share line one, D has line two.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         irq_one_reg <= 1'b0;
         irq_two_reg <= 1'b0;
      end else begin
         irq_one_reg <= (pend_reg.a && irq_enable_reg.a) ||
                        (pend_reg.b && irq_enable_reg.b) ||
                        (pend_reg.c && irq_enable_reg.c);
         irq_two_reg <= pend_reg.d && irq_enable_reg.d;
      end
   end

   // Pin drive: starts at the programmed level, toggles on each PWM underflow.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg  <= 1'b0;
      end else begin
         pin_oe_reg <= pwm_active && mode_reg.pin_function_enable;
         if (!pwm_active || !mode_reg.pin_function_enable || !run_one) begin
            pin_out_reg <= mode_reg.initial_pin_level;
         end else if (underflow_one) begin
            pin_out_reg <= ~pin_out_reg;
         end
      end
   end

   // Read data stand for one cycle after the read strobe; unmapped offsets read zero.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            dtp_pkg::OFS_COUNTER_ONE:  rdata_reg <= counter_one_reg;
            dtp_pkg::OFS_RELOAD_A:     rdata_reg <= reload_capture_a_reg;
            dtp_pkg::OFS_RELOAD_B:     rdata_reg <= reload_capture_b_reg;
            dtp_pkg::OFS_COUNTER_TWO:  rdata_reg <= counter_two_reg;
            dtp_pkg::OFS_PRESCALE:     rdata_reg <= {11'h000, prescale_divisor_reg};
            dtp_pkg::OFS_CLOCK_SELECT: rdata_reg <= {10'h000, clock_select_reg};
            dtp_pkg::OFS_MODE_CONTROL: rdata_reg <= {12'h000, mode_reg};
            dtp_pkg::OFS_IRQ_CONTROL:  rdata_reg <= {8'h00, pend_reg, irq_enable_reg};
            default:                   rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   // Fits bus data to the counter width.
   function automatic logic [CNT_W-1:0] reload_data(input logic [dtp_pkg::DATA_W-1:0] d);
      reload_data = d[CNT_W-1:0];
   endfunction

   // Outputs come straight from flip-flops.
   assign reg_rdata        = rdata_reg;
   assign timer_io_pin_out = pin_out_reg;
   assign timer_io_pin_oe  = pin_oe_reg;
   assign irq_timer_one    = irq_one_reg;
   assign irq_timer_two    = irq_two_reg;

endmodule
`default_nettype wire

/* test/dtp_pin_model.sv */
// External side of the timer pin and the slow clock source.
// Assumes the testbench calls its tasks right after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module dtp_pin_model (
   input  wire logic clk,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      slow_clk,
   output logic      pin_in
);
   logic drive_reg;

   // The timer wins the wire while it drives, else the external source.
   assign pin_in = pin_oe ? pin_out : drive_reg;

   // Both lines start low; the slow clock stands still between bursts.
   initial begin
      slow_clk  = 1'b0;
      drive_reg = 1'b0;
   end

   // Slow clock burst of eight system clocks a period, well under a quarter rate.
   task automatic slow_cycles(input int cnt);
      repeat (cnt) begin
         repeat (4) @(posedge clk);
         slow_clk <= 1'b1;
         repeat (4) @(posedge clk);
         slow_clk <= 1'b0;
      end
   endtask

   // Drives a level and holds it for one whole slow clock period of eight system clocks.
   task automatic drive(input logic lvl);
      @(posedge clk);
      drive_reg <= lvl;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* test/dtp_timer_chk.sv */
// Checker for the dual timer: register reads, pin enable and level, interrupt masks.
// Assumes it is bound to dtp_timer and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dtp_timer_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        timer_io_pin_out,
   input wire logic        timer_io_pin_oe,
   input wire logic        irq_timer_one,
   input wire logic        irq_timer_two
);
   logic [3:0] mode_reg;
   logic [2:0] sel_reg;
   logic [3:0] en_reg;
   logic [1:0] quiet_reg;
   logic       cfg_wr;
   logic       mapped;

   // Configuration writes and the mapped address range.
   assign cfg_wr = reg_wr && (reg_addr == dtp_pkg::OFS_MODE_CONTROL ||
      reg_addr == dtp_pkg::OFS_CLOCK_SELECT || reg_addr == dtp_pkg::OFS_IRQ_CONTROL);
   assign mapped = reg_addr >= 8'h40 && reg_addr <= 8'h50 && !reg_addr[0];

   // Shadows of mode, selector and enables, and cycles since they last changed.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg  <= 4'h0;
         sel_reg   <= 3'h0;
         en_reg    <= 4'h0;
         quiet_reg <= 2'h3;
      end else begin
         if (reg_wr && reg_addr == dtp_pkg::OFS_MODE_CONTROL) mode_reg <= reg_wdata[3:0];
         if (reg_wr && reg_addr == dtp_pkg::OFS_CLOCK_SELECT) sel_reg <= reg_wdata[2:0];
         if (reg_wr && reg_addr == dtp_pkg::OFS_IRQ_CONTROL) en_reg <= reg_wdata[3:0];
         if (cfg_wr) quiet_reg <= 2'h0;
         else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
   a_unmapped_zero: assert property (
      reg_rd && !mapped |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   a_prescale_width: assert property (
      reg_rd && reg_addr == dtp_pkg::OFS_PRESCALE |=> reg_rdata[15:5] == 11'h000)
      else $error("prescale upper bits set");
   a_select_width: assert property (
      reg_rd && reg_addr == dtp_pkg::OFS_CLOCK_SELECT |=> reg_rdata[15:6] == 10'h000)
      else $error("select upper bits set");
   a_clear_reads_zero: assert property (
      reg_rd && reg_addr == dtp_pkg::OFS_IRQ_CLEAR |=> reg_rdata == 16'h0000)
      else $error("clear register read not zero");
   a_pin_enable: assert property (
      quiet_reg == 2'h3 |-> timer_io_pin_oe == (mode_reg[2] && !mode_reg[0]))
      else $error("pin enable wrong for mode");
   a_pin_stopped: assert property (
      quiet_reg == 2'h3 && sel_reg == 3'h0 && timer_io_pin_oe |-> timer_io_pin_out == mode_reg[3])
      else $error("stopped pin not at initial level");
   a_irq_one_mask: assert property (
      quiet_reg == 2'h3 && en_reg[2:0] == 3'h0 |-> !irq_timer_one) else $error("masked irq one");
   a_irq_two_mask: assert property (
      quiet_reg == 2'h3 && !en_reg[3] |-> !irq_timer_two) else $error("masked irq two");
endmodule
`default_nettype wire

/* test/tb_dual_timer_pwm_capture.sv */
// Testbench for the dual timer: register tasks, PWM timing, capture and slow clock.
// Assumes the timer, its checker and the pin model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_dual_timer_pwm_capture;
   localparam logic [7:0] MODE = dtp_pkg::OFS_MODE_CONTROL;
   localparam logic [7:0] CSEL = dtp_pkg::OFS_CLOCK_SELECT;
   localparam logic [7:0] IRQC = dtp_pkg::OFS_IRQ_CONTROL;
   localparam logic [7:0] CNT1 = dtp_pkg::OFS_COUNTER_ONE;
   localparam logic [7:0] RLA  = dtp_pkg::OFS_RELOAD_A;
   logic        clk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        slow_clk;
   logic        pin;
   logic        pin_out;
   logic        pin_oe;
   logic        irq_one;
   logic        irq_two;
   int          fails;
   int          comparisons;
   int          n;

   dtp_timer i_dtp_timer (
      .clk              (clk),
      .rst_n            (rst_n),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .slow_clk         (slow_clk),
      .timer_io_pin_in  (pin),
      .timer_io_pin_out (pin_out),
      .timer_io_pin_oe  (pin_oe),
      .irq_timer_one    (irq_one),
      .irq_timer_two    (irq_two)
   );
   dtp_pin_model i_dtp_pin_model (
      .clk      (clk),
      .pin_out  (pin_out),
      .pin_oe   (pin_oe),
      .slow_clk (slow_clk),
      .pin_in   (pin)
   );

   // System clock of 50 ns.
   always #25 clk = ~clk;

   // Compares one value and reports a mismatch.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One write cycle, then one idle edge.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   // One read cycle; the data are sampled mid-cycle in the cycle after it, while they stand.
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(what, exp, reg_rdata);
      @(posedge clk);
   endtask

   // Counts clocks until the pin level changes.
   task automatic gap(output int cnt);
      logic p;
      p   = pin;
      cnt = 0;
      while (pin === p && cnt < 400) begin
         @(negedge clk);
         cnt++;
      end
      @(posedge clk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim;
   end

   // Main sequence.
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wr(8'h52, 16'hFFFF);
      for (int a = 8'h40; a <= 8'h52; a += 2) rdchk(8'(a), 16'h0000, "reset read");
      $display("test reset done");
      wr(dtp_pkg::OFS_PRESCALE, 16'hFFFF);
      rdchk(dtp_pkg::OFS_PRESCALE, 16'h001F, "prescale");
      wr(RLA, 16'h0003);
      wr(dtp_pkg::OFS_RELOAD_B, 16'h0005);
      wr(MODE, 16'h0004);
      wr(IRQC, 16'h0003);
      wr(CSEL, 16'h0001);
      gap(n);
      gap(n);
      chk("gap a", 16'h0080, 16'(n));
      gap(n);
      chk("gap b", 16'h00C0, 16'(n));
      chk("irq one", 16'h0001, {15'h0000, irq_one});
      wr(CSEL, 16'h0000);
      rdchk(IRQC, 16'h0033, "pending ab");
      wr(dtp_pkg::OFS_IRQ_CLEAR, 16'h0003);
      rdchk(IRQC, 16'h0003, "cleared ab");
      wr(CNT1, 16'h0000);
      wr(CSEL, 16'h0001);
      gap(n);
      gap(n);
      chk("restart gap", 16'h0080, 16'(n));
      wr(CSEL, 16'h0000);
      wr(MODE, 16'h000C);
      repeat (3) @(posedge clk);
      chk("initial level", 16'h0001, {15'h0000, pin});
      $display("test pwm done");
      wr(dtp_pkg::OFS_COUNTER_TWO, 16'h0003);
      wr(IRQC, 16'h0008);
      wr(CSEL, 16'h0020);
      i_dtp_pin_model.slow_cycles(3);
      rdchk(dtp_pkg::OFS_COUNTER_TWO, 16'h0000, "slow count");
      chk("irq two idle", 16'h0000, {15'h0000, irq_two});
      i_dtp_pin_model.slow_cycles(1);
      repeat (4) @(posedge clk);
      rdchk(dtp_pkg::OFS_COUNTER_TWO, 16'hFFFF, "wrap two");
      chk("irq two", 16'h0001, {15'h0000, irq_two});
      wr(CSEL, 16'h0000);
      $display("test counter two done");
      wr(IRQC, 16'h0005);
      wr(MODE, 16'h0001);
      wr(CNT1, 16'h1234);
      wr(dtp_pkg::OFS_IRQ_CLEAR, 16'h000F);
      i_dtp_pin_model.drive(1'b1);
      rdchk(RLA, 16'h1234, "capture");
      rdchk(CNT1, 16'h1234, "no preset");
      rdchk(IRQC, 16'h0015, "pending a");
      wr(MODE, 16'h0003);
      wr(CNT1, 16'h5678);
      i_dtp_pin_model.drive(1'b0);
      wr(CNT1, 16'h0ABC);
      i_dtp_pin_model.drive(1'b1);
      rdchk(RLA, 16'h5678, "falling edge");
      wr(MODE, 16'h0005);
      wr(CNT1, 16'h0042);
      i_dtp_pin_model.drive(1'b0);
      i_dtp_pin_model.drive(1'b1);
      rdchk(RLA, 16'h0042, "preset capture");
      rdchk(CNT1, 16'hFFFF, "preset value");
      wr(dtp_pkg::OFS_IRQ_CLEAR, 16'h000F);
      wr(CNT1, 16'h0000);
      wr(CSEL, 16'h0001);
      repeat (40) @(posedge clk);
      wr(CSEL, 16'h0000);
      rdchk(IRQC, 16'h0045, "pending c");
      $display("test capture done");
      end_sim;
   end
endmodule

bind dtp_timer dtp_timer_chk i_dtp_timer_chk (
   .clk              (clk),
   .rst_n            (rst_n),
   .reg_addr         (reg_addr),
   .reg_wdata        (reg_wdata),
   .reg_wr           (reg_wr),
   .reg_rd           (reg_rd),
   .reg_rdata        (reg_rdata),
   .timer_io_pin_out (timer_io_pin_out),
   .timer_io_pin_oe  (timer_io_pin_oe),
   .irq_timer_one    (irq_timer_one),
   .irq_timer_two    (irq_timer_two)
);
`default_nettype wire
